//--- design/tac_ctrl.sv
module tac_ctrl import tac_pkg::*; #(
  parameter int TEMP_CYCLES = TEMP_CYC,   // Temperature conversion length
  parameter int VOLT_CYCLES = VOLT_CYC    // Voltage conversion length
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  input  wire logic [12:0] adc_code,
  output logic             dout,
  output logic             dout_oe,
  output logic             conversion_strobe,
  output logic [1:0]       power_mode,
  output logic             ref_internal,
  output logic [3:0]       input_select,
  output logic             adc_on,
  output logic             refbuf_on,
  output logic             temp_bias_on
);

  // Decoding helpers shared by the receiver and the command stage
  function automatic logic is_conv(input logic [7:0] b);
    return b[6:4] == CONV_ID;
  endfunction

  function automatic logic is_cfg(input logic [7:0] b);
    return b[6:3] == CFG_ID;
  endfunction

  function automatic logic is_temp(input logic [3:0] s);
    return s == SEL_INT_DIODE || s == SEL_EXT_DIODE1 || s == SEL_EXT_DIODE2;
  endfunction

  // Packs the converter code into the sixteen-bit output word
  function automatic logic [15:0] pack(input logic t, input logic [12:0] c);
    if (t)
      return {2'b00, c[11:0], 2'b00};
    else
      return {c[12], c, 2'b00};
  endfunction

  // ---------------- Link side, serial clock domain ----------------
  logic        link_clr;     // Reset of link logic, from the system domain
  tac_rx_t     rx_state;     // Receiver hunting, shifting or draining
  logic [3:0]  rx_cnt;       // Command bits taken so far
  logic [6:0]  rx_sr;        // Command shift register
  logic [4:0]  drain_cnt;    // Result bits clocked out so far
  logic [7:0]  rx_hold;      // Last complete command byte
  logic        rx_tgl;       // Toggles once per complete byte
  logic        fall_tgl;     // Toggles once per falling edge while selected
  logic        rx_done;      // Last command bit on this edge
  logic [7:0]  rx_byte;      // Byte as it completes

  assign rx_done = (rx_state == TAC_SHIFT) && (rx_cnt == LAST_CMD_BIT);
  assign rx_byte = {rx_sr, din};

  // Receiver; raising select sends it back to hunting for a start bit
  always_ff @(posedge sclk or posedge cs_n or posedge link_clr) begin
    if (cs_n || link_clr) begin
      rx_state  <= TAC_HUNT;
      rx_cnt    <= 4'h0;
      rx_sr     <= 7'h00;
      drain_cnt <= 5'h00;
    end else begin
      unique case (rx_state)
        TAC_HUNT: begin
          // First one after select falls is the start bit
          if (din) begin
            rx_state <= TAC_SHIFT;
            rx_cnt   <= 4'h1;
            rx_sr    <= 7'h01;
          end
        end
        TAC_SHIFT: begin
          rx_sr  <= rx_byte[6:0];
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_done) begin
            // Conversion byte: drain sixteen result bits before hunting again
            rx_state  <= is_conv(rx_byte) ? TAC_DRAIN : TAC_HUNT;
            drain_cnt <= 5'h00;
          end
        end
        TAC_DRAIN: begin
          // Host keeps the clock still during conversion, so every edge here
          // belongs to the result
          drain_cnt <= drain_cnt + 5'h01;
          if (drain_cnt == RESULT_BITS - 5'h01)
            rx_state <= TAC_HUNT;
        end
        default: rx_state <= TAC_HUNT;
      endcase
    end
  end

  // Byte hand-off; not cleared by select so no false event is made
  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      rx_hold <= 8'h00;
      rx_tgl  <= 1'b0;
    end else if (!cs_n && rx_done) begin
      rx_hold <= rx_byte;
      rx_tgl  <= ~rx_tgl;
    end
  end

  // Falling edges while selected advance the output shifter
  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr)
      fall_tgl <= 1'b0;
    else if (!cs_n)
      fall_tgl <= ~fall_tgl;
  end

  // ---------------- System clock domain ----------------
  logic [1:0]  rx_sync;      // Byte toggle synchroniser
  logic [1:0]  fall_sync;    // Falling edge toggle synchroniser
  logic [1:0]  cs_sync;      // Select synchroniser
  logic        rx_seen;      // Last byte toggle acted on
  logic        fall_seen;    // Last falling toggle acted on
  logic        rx_evt;       // New command byte ready
  logic        fall_evt;     // One falling edge seen
  logic [7:0]  cmd;          // Command byte, stable for eight edges
  logic        ref_sel;      // Stored reference choice
  tac_cv_t     cv_state;     // Conversion sequencer
  logic [CNT_W-1:0] cv_cnt;  // Cycles left in current phase
  logic        cv_temp;      // Current conversion is temperature
  logic [15:0] out_sr;       // Output word, zeros fill behind
  logic        conv_go;      // Accepted conversion byte
  logic        cfg_go;       // Accepted configuration byte
  logic        conv_end;     // Last conversion cycle
  logic [15:0] res_word;     // Packed result of the current conversion

  assign rx_evt   = ce && (rx_sync[1] != rx_seen);
  assign fall_evt = ce && (fall_sync[1] != fall_seen);
  assign cmd      = rx_hold;
  assign cfg_go   = rx_evt && is_cfg(cmd);
  assign conv_go  = rx_evt && is_conv(cmd) && (cv_state == TAC_IDLE);
  assign conv_end = ce && (cv_state == TAC_CONV) && (cv_cnt == '0);
  // Packing is named once so the shifter and its check see one value
  assign res_word = pack(cv_temp, adc_code);

  // Link reset is a register so the serial side sees a clean level
  always_ff @(posedge clk) begin
    link_clr <= !rstn;
  end

  // Two-flop synchronisers; only the second stage is read
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_sync   <= 2'b00;
      fall_sync <= 2'b00;
      cs_sync   <= 2'b11;
    end else if (ce) begin
      rx_sync   <= {rx_sync[0], rx_tgl};
      fall_sync <= {fall_sync[0], fall_tgl};
      cs_sync   <= {cs_sync[0], cs_n};
    end
  end

  // Event edge trackers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_seen   <= 1'b0;
      fall_seen <= 1'b0;
    end else if (ce) begin
      rx_seen   <= rx_sync[1];
      fall_seen <= fall_sync[1];
    end
  end

  // Configuration store; anything not recognised leaves it alone
  always_ff @(posedge clk) begin
    if (!rstn) begin
      power_mode <= PM_SHUTDOWN;
      ref_sel    <= 1'b0;
    end else if (cfg_go) begin
      power_mode <= cmd[PM_LSB +: 2];
      ref_sel    <= cmd[REF_BIT];
    end
  end

  // Input selection latched per conversion, kept until the next
  always_ff @(posedge clk) begin
    if (!rstn) begin
      input_select <= 4'h0;
      cv_temp      <= 1'b0;
    end else if (conv_go) begin
      input_select <= cmd[3:0];
      cv_temp      <= is_temp(cmd[3:0]);
    end
  end

  // Sequencer: optional wake-up, then the conversion itself.
  // Stored configuration is reused, so one conversion byte suffices.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cv_state <= TAC_IDLE;
      cv_cnt   <= '0;
    end else if (ce) begin
      unique case (cv_state)
        TAC_IDLE: begin
          if (conv_go) begin
            if (power_mode == PM_NORMAL) begin
              cv_state <= TAC_CONV;
              cv_cnt   <= is_temp(cmd[3:0]) ? CNT_W'(TEMP_CYCLES - 1)
                                            : CNT_W'(VOLT_CYCLES - 1);
            end else begin
              // Any powered-down mode first waits for the buffer to settle
              cv_state <= TAC_WAKE;
              cv_cnt   <= CNT_W'(WAKE_CYC - 1);
            end
          end
        end
        TAC_WAKE: begin
          if (cv_cnt == '0) begin
            cv_state <= TAC_CONV;
            cv_cnt   <= cv_temp ? CNT_W'(TEMP_CYCLES - 1)
                                : CNT_W'(VOLT_CYCLES - 1);
          end else begin
            cv_cnt <= cv_cnt - CNT_W'(1);
          end
        end
        TAC_CONV: begin
          if (cv_cnt == '0)
            cv_state <= TAC_IDLE;
          else
            cv_cnt <= cv_cnt - CNT_W'(1);
        end
        default: cv_state <= TAC_IDLE;
      endcase
    end
  end

  // Strobe is low from conversion byte to result; select has no say here
  always_ff @(posedge clk) begin
    if (!rstn)
      conversion_strobe <= 1'b1;
    else if (conv_go)
      conversion_strobe <= 1'b0;
    else if (conv_end)
      conversion_strobe <= 1'b1;
  end

  // Output shifter: loads at the end, then one bit per falling edge.
  // Shutdown wipes the result so stale data cannot be read back.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_sr <= RESULT_RST;
      dout   <= 1'b0;
    end else if (conv_end) begin
      out_sr <= {res_word[14:0], 1'b0};
      dout   <= res_word[15];
    end else if (cfg_go && cmd[PM_LSB +: 2] == PM_SHUTDOWN) begin
      out_sr <= RESULT_RST;
      dout   <= 1'b0;
    end else if (fall_evt && cv_state == TAC_IDLE && !cs_sync[1]) begin
      out_sr <= {out_sr[14:0], 1'b0};
      dout   <= out_sr[15];
    end
  end

  // Output pin is released while deselected
  always_ff @(posedge clk) begin
    if (!rstn)
      dout_oe <= 1'b0;
    else if (ce)
      dout_oe <= !cs_sync[1];
  end

  // Analog power controls follow mode and activity
  always_ff @(posedge clk) begin
    if (!rstn) begin
      adc_on       <= 1'b0;
      refbuf_on    <= 1'b0;
      temp_bias_on <= 1'b0;
      ref_internal <= 1'b0;
    end else if (ce) begin
      adc_on       <= (power_mode == PM_NORMAL) || (cv_state != TAC_IDLE);
      refbuf_on    <= (power_mode == PM_NORMAL) || (power_mode == PM_STBY_PLUS)
                      || (cv_state != TAC_IDLE);
      temp_bias_on <= (cv_state != TAC_IDLE) && cv_temp;
      ref_internal <= ref_sel || ((cv_state != TAC_IDLE) && cv_temp);
    end
  end

  // ---------------- Checks ----------------
  logic [CNT_W:0] low_len;   // Cycles the strobe has been low
  logic           last_temp; // Kind of the conversion being timed

  // Counts only enabled cycles, so a frozen clock enable does not
  // stretch the figure that the length check compares against
  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_len   <= '0;
      last_temp <= 1'b0;
    end else if (conv_go) begin
      low_len   <= '0;
      last_temp <= is_temp(cmd[3:0]);
    end else if (ce && !conversion_strobe) begin
      low_len <= low_len + (CNT_W+1)'(1);
    end
  end

  // All checks below run on the system clock; all but reset_mode_a pause during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  reset_mode_a: assert property (disable iff (1'b0)
    !rstn |=> power_mode == PM_SHUTDOWN && conversion_strobe)
    else $error("power mode not shutdown after reset");

  strobe_fall_a: assert property (conv_go |=> !conversion_strobe)
    else $error("strobe did not fall on conversion byte");

  conv_len_a: assert property (conv_end && power_mode == PM_NORMAL |->
    low_len == (CNT_W+1)'((last_temp ? TEMP_CYCLES : VOLT_CYCLES) - 1))
    else $error("conversion length wrong");

  msb_load_a: assert property (conv_end |=> conversion_strobe
    && dout == $past(res_word[15]))
    else $error("result msb not present at strobe rise");

  shift_out_a: assert property (fall_evt && cv_state == TAC_IDLE
    && !cs_sync[1] && !conv_go && !cfg_go |=> dout == $past(out_sr[15]))
    else $error("output bit not advanced on falling edge");

  cfg_load_a: assert property (cfg_go |=> power_mode == $past(cmd[2:1])
    && ref_sel == $past(cmd[0]))
    else $error("configuration not stored");

  sel_latch_a: assert property (conv_go |=> input_select == $past(cmd[3:0]))
    else $error("input selection not latched");

  bad_cmd_a: assert property (rx_evt && !is_cfg(cmd) && !is_conv(cmd)
    |=> $stable(power_mode) && $stable(input_select) && $stable(cv_state))
    else $error("unrecognised byte changed state");

  temp_ref_a: assert property (cv_state == TAC_CONV && cv_temp
    |-> ##[1:2] ref_internal)
    else $error("temperature conversion without internal reference");

  shutdown_clr_a: assert property (cfg_go && cmd[2:1] == PM_SHUTDOWN
    && !conv_end |=> out_sr == RESULT_RST && !dout)
    else $error("result not cleared on shutdown");

  cs_hold_a: assert property (!conversion_strobe && cs_sync[1]
    && !conv_end |=> !conversion_strobe)
    else $error("select disturbed a conversion");

  // Strobe is low exactly while the sequencer is waking or converting
  strobe_state_a: assert property (
    conversion_strobe == (cv_state == TAC_IDLE))
    else $error("strobe level disagrees with sequencer state");

  // Idle in shutdown leaves converter and buffer unpowered
  pwr_down_a: assert property (ce && power_mode == PM_SHUTDOWN
    && cv_state == TAC_IDLE |=> !adc_on && !refbuf_on)
    else $error("power left on in shutdown");

  // Selection moves only when a conversion byte is accepted
  sel_stable_a: assert property (!conv_go
    |=> $stable(input_select))
    else $error("input selection changed without a conversion byte");

  // Output enable tracks the synchronised select one cycle later
  oe_follow_a: assert property (ce
    |=> dout_oe == !$past(cs_sync[1]))
    else $error("output enable does not follow select");

endmodule // tac_ctrl

//--- design/tac_pkg.sv
// What this block does
// - Command bits sampled on rising edge, select low
// - Start bit hunted after select, config, or output
// - Result shifted out on falling edges, MSB first
// - Temperature word: two lead, twelve code, two zeros
// - Voltage word: sign copy, ten code, three sub, two zeros
// - Shutdown mode after reset until configured
// - Stored configuration reused by later conversions
// - Strobe falls at conversion byte end
// - Conversion lasts 2.2 ms or 1.1 ms
// - MSB at strobe rise, zeros past sixteen
// - Select high blocks shifting, conversion continues
// - Pattern 010 converts, pattern 0000 configures
// - Conversion byte low nibble selects inputs
// - Configuration bit zero selects internal reference
// - Configuration bits two, one select power mode
// - Temperature conversions force internal reference
// - Standby powers down; standby-plus keeps buffer; wake
// - Shutdown powers all down, clears result
// - Supply monitor uses the voltage result path
package tac_pkg;
  // Clock rate and documented times
  localparam int CLK_KHZ         = 10000;
  localparam int T_TEMP_US       = 2200;
  localparam int T_VOLT_US       = 1100;
  localparam int T_WAKE_US       = 100;
  localparam int TEMP_CYC        = (T_TEMP_US * CLK_KHZ) / 1000;
  localparam int VOLT_CYC        = (T_VOLT_US * CLK_KHZ) / 1000;
  localparam int WAKE_CYC        = (T_WAKE_US * CLK_KHZ) / 1000;
  localparam int CNT_W           = 16;
  // Command byte identifier fields
  localparam logic [2:0] CONV_ID = 3'h2;
  localparam logic [3:0] CFG_ID  = 4'h0;
  localparam int REF_BIT         = 0;
  localparam int PM_LSB          = 1;
  // Power mode encodings
  localparam logic [1:0] PM_SHUTDOWN = 2'h0;
  localparam logic [1:0] PM_STBY_PLUS = 2'h1;
  localparam logic [1:0] PM_STANDBY  = 2'h2;
  localparam logic [1:0] PM_NORMAL   = 2'h3;
  // Input selections that run a temperature measurement
  localparam logic [3:0] SEL_INT_DIODE = 4'h7;
  localparam logic [3:0] SEL_EXT_DIODE1 = 4'hC;
  localparam logic [3:0] SEL_EXT_DIODE2 = 4'hD;
  // Serial framing
  localparam logic [3:0] LAST_CMD_BIT = 4'h7;
  localparam logic [4:0] RESULT_BITS  = 5'h10;
  localparam logic [15:0] RESULT_RST  = 16'h0000;
  typedef enum logic [1:0] {TAC_HUNT, TAC_SHIFT, TAC_DRAIN} tac_rx_t;
  typedef enum logic [1:0] {TAC_IDLE, TAC_WAKE, TAC_CONV} tac_cv_t;
endpackage

//--- verif/tac_host_model.sv
// Serial host model: masters the link clock, sends commands, reads results
module tac_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  timeunit 1ns;
  timeprecision 1ns;

  // Half period; slower than the nominal link rate so crossings settle
  localparam int HALF = 500;

  // Idle levels: clock low outside frames, nothing selected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // Open a frame, offset from the system clock phase
  task automatic frame_on();
    #13 cs_n = 1'b0;
    din = 1'b0;
    #HALF;
  endtask

  // Close a frame; a released line shows the inverse of its last value
  task automatic frame_off();
    #HALF cs_n = 1'b1;
    din = ~din;
  endtask

  // One command byte, MSB first, data set up half a period before each rise
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      din = b[i];
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
    end
    // Idle the line a step later so a following byte never writes it twice
    #1 din = 1'b0;
  endtask

  // Read n result bits; only called once the strobe is high again
  task automatic read_bits(input int n, output logic [15:0] w);
    w = 16'h0000;
    for (int i = 0; i < n; i++) begin
      w = {w[14:0], dout};
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
      #HALF;
    end
  endtask
endmodule // tac_host_model

//--- verif/tb_top.sv
// Self-checking bench for the converter command sequencer
module tb_top import tac_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int TC = 40; // Shortened temperature conversion
  localparam int VC = 20; // Shortened voltage conversion

  // One table row: command bytes, converter code, expected outputs
  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  conv;
    logic [12:0] code;
    logic [15:0] word;
    logic        ref_int;
    logic        temp;
  } tac_row_t;

  logic        clk      = 1'b0;
  logic        rstn     = 1'b0;
  logic        ce       = 1'b1;
  logic [12:0] adc_code = 13'h0000;
  wire logic   sclk, cs_n, din, dout, dout_oe, conversion_strobe;
  wire logic   ref_internal, adc_on, refbuf_on, temp_bias_on;
  wire logic [1:0] power_mode;
  wire logic [3:0] input_select;
  int          fail_count = 0;
  int          tests_run  = 0;
  int          n;
  logic [15:0] w;

  // A zero config entry means the stored setup is reused
  tac_row_t rows [5] = '{
    '{8'h87, 8'hA0, 13'h1ABC, 16'hEAF0, 1'b1, 1'b0},
    '{8'h86, 8'hA7, 13'h0FFF, 16'h3FFC, 1'b1, 1'b1},
    '{8'h00, 8'hAB, 13'h0040, 16'h0100, 1'b0, 1'b0},
    '{8'h00, 8'hAC, 13'h1555, 16'h1554, 1'b1, 1'b1},
    '{8'h00, 8'hAD, 13'h0001, 16'h0004, 1'b1, 1'b1}
  };

  always #50 clk = ~clk;

  tac_ctrl #(.TEMP_CYCLES(TC), .VOLT_CYCLES(VC)) dut_u (
    .clk(clk), .rstn(rstn), .ce(ce), .sclk(sclk), .cs_n(cs_n), .din(din),
    .adc_code(adc_code), .dout(dout), .dout_oe(dout_oe),
    .conversion_strobe(conversion_strobe), .power_mode(power_mode),
    .ref_internal(ref_internal), .input_select(input_select), .adc_on(adc_on),
    .refbuf_on(refbuf_on), .temp_bias_on(temp_bias_on)
  );

  tac_host_model host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  // Compare and count; four-state so an unknown never matches
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // Bounded wait for a strobe level, sampled away from the active edge
  task automatic wait_strobe(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (conversion_strobe !== lvl && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
  endtask

  // Send a conversion byte and see the strobe drop
  task automatic start_conv(input logic [7:0] conv);
    int c;
    host_u.send_byte(conv);
    wait_strobe(1'b0, 10, c);
    chk(conversion_strobe, 1'b0);
  endtask

  // Counts, verdict and end of run
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog: far beyond the expected run of well under a millisecond
  initial begin
    #3000000;
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(negedge clk);
    chk(power_mode, PM_SHUTDOWN);
    chk(conversion_strobe, 1'b1);
    chk(dout_oe, 1'b0);
    chk(adc_on, 1'b0);
    $display("test reset done");
    // Whole table in one frame: start bits follow config and 16 outputs
    host_u.frame_on();
    chk(dout_oe, 1'b1);
    foreach (rows[i]) begin
      @(posedge clk);
      adc_code <= rows[i].code;
      if (rows[i].cfg != 8'h00) begin
        host_u.send_byte(rows[i].cfg);
      end
      start_conv(rows[i].conv);
      @(negedge clk); // Power controls follow the sequencer one cycle later
      chk(input_select, rows[i].conv[3:0]);
      chk(ref_internal, rows[i].ref_int);
      chk(power_mode, PM_NORMAL);
      chk(adc_on, 1'b1);
      chk(temp_bias_on, rows[i].temp);
      wait_strobe(1'b1, TC + 20, n);
      chk(n + 4 >= (rows[i].temp ? TC : VC) && n <= (rows[i].temp ? TC : VC) + 2, 1);
      @(negedge clk);
      host_u.read_bits(16, w);
      chk(w, rows[i].word);
    end
    host_u.read_bits(4, w);
    chk(w, 16'h0000);
    host_u.frame_off();
    $display("test table done");
    // Unrecognised byte: no conversion, nothing changes
    host_u.frame_on();
    host_u.send_byte(8'hB5);
    repeat (40) @(negedge clk);
    chk(conversion_strobe, 1'b1);
    chk(input_select, 4'hD);
    chk(power_mode, PM_NORMAL);
    host_u.frame_off();
    $display("test ignored byte done");
    // Deselect during a conversion: it still finishes, result intact
    host_u.frame_on();
    @(posedge clk);
    adc_code <= 13'h0155;
    start_conv(8'hA1);
    host_u.frame_off();
    repeat (4) @(negedge clk);
    chk(dout_oe, 1'b0);
    // Clock enable low freezes the sequencer, so the strobe stays low longer
    @(posedge clk);
    ce <= 1'b0;
    repeat (30) @(posedge clk);
    ce <= 1'b1;
    @(negedge clk);
    chk(conversion_strobe, 1'b0);
    wait_strobe(1'b1, VC + 20, n);
    chk(conversion_strobe, 1'b1);
    host_u.frame_on();
    host_u.read_bits(16, w);
    chk(w, 16'h0554);
    host_u.frame_off();
    $display("test deselect done");
    // Power modes: shutdown clears the result, standby variants, wake-up
    host_u.frame_on();
    @(posedge clk);
    adc_code <= 13'h1FFF;
    start_conv(8'hA2);
    wait_strobe(1'b1, VC + 20, n);
    chk(dout, 1'b1);
    host_u.frame_off();
    host_u.frame_on();
    host_u.send_byte(8'h80);
    repeat (8) @(negedge clk);
    chk(power_mode, PM_SHUTDOWN);
    chk(dout, 1'b0);
    chk(refbuf_on, 1'b0);
    host_u.send_byte(8'h85);
    repeat (8) @(negedge clk);
    chk(power_mode, PM_STANDBY);
    chk(refbuf_on, 1'b0);
    chk(adc_on, 1'b0);
    host_u.send_byte(8'h83);
    repeat (8) @(negedge clk);
    chk(power_mode, PM_STBY_PLUS);
    chk(refbuf_on, 1'b1);
    start_conv(8'hA3);
    wait_strobe(1'b1, WAKE_CYC + VC + 20, n);
    chk(n + 4 >= WAKE_CYC + VC && n <= WAKE_CYC + VC + 2, 1);
    host_u.frame_off();
    $display("test power modes done");
    print_verdict();
  end
endmodule // tb_top
